/* inc/rwc_defines.vh */
// Constants for the reset and watchdog controller
`ifndef RWC_DEFINES_VH
`define RWC_DEFINES_VH

// Register indexes on the plain register port
`define RWC_ADDR_RST_STATUS   4'h0
`define RWC_ADDR_SW_RESET     4'h1
`define RWC_ADDR_WDOG_CTRL     4'h2
`define RWC_ADDR_WDOG_WINCTRL  4'h3
`define RWC_ADDR_WDOG_LOCK     4'h4
`define RWC_ADDR_PROT_KEY      4'h5
`define RWC_ADDR_BOD_CTRL      4'h6
`define RWC_ADDR_BOOT_CTRL     4'h7
`define RWC_ADDR_WDOG_COUNT_LO 4'h8
`define RWC_ADDR_WDOG_COUNT_HI 4'h9

// Reset status bit positions
`define RWC_ST_POR   0
`define RWC_ST_EXT   1
`define RWC_ST_WDOG  2
`define RWC_ST_BOD   3
`define RWC_ST_JTAG  4
`define RWC_ST_DBG   5
`define RWC_ST_SW    6

// Field positions
`define RWC_EN_BIT      0
`define RWC_PER_LSB     1
`define RWC_PER_MSB     4
`define RWC_BOD_LVL_MSB 2

// Reset values
`define RWC_WDOG_CTRL_RST 8'h00
`define RWC_WIN_CTRL_RST  8'h00
`define RWC_BOD_CTRL_RST  3'h0
`define RWC_BOOT_CTRL_RST 1'h0

// Protection key and window length in clk_sys_i cycles
`define RWC_PROT_KEY    8'hD8
`define RWC_PROT_CYCLES 3'h4

// Watchdog timing: 32 kHz oscillator divided by 32 gives 1 kHz
`define RWC_LPO_DIV      5'h1F
`define RWC_WDOG_BASE_MS 14'h0008
`define RWC_WDOG_PER_MAX 4'hA

// Reset vector of the boot section, word address
`define RWC_BOOT_VECTOR  16'h8000

// Length of a stretched internal reset request, clk_sys_i cycles
`define RWC_RST_HOLD     5'h10

`endif

/* hw/rwc_top.v */
// Reset sequencer with watchdog, reset cause log and timed-write guard
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Any reset source drives the device reset with no clock needed; watchdog and software resets go through the clk_sys_i hold counter.
// RULE_02: Device reset restores control registers; memory contents stay.
// RULE_03: Reset vector is address 0, or boot section start when chosen.
// RULE_04: I/O pins go high impedance at once while any reset is active.
// RULE_05: Cause of the last reset is kept in a readable status register.
// RULE_06: Device stays in reset while supply is below power-on threshold.
// RULE_07: Device stays in reset while the external reset pin is low.
// RULE_08: Watchdog expiry resets the device only while watchdog is enabled.
// RULE_09: Enabled brown-out detector below its set level resets device.
// RULE_10: Device stays in reset while the scan-chain reset bit is one.
// RULE_11: Debug port reset request resets the device.
// RULE_12: Software reset needs the timed protected write; plain writes fail.
// RULE_13: Eleven watchdog periods, from 8 ms up to 8 s.
// RULE_14: Watchdog counts a 1 kHz tick from the 32 kHz low-power clock.
// RULE_15: Enabled watchdog counts always and resets unless restarted.
// RULE_16: Software issues restart instructions to clear the watchdog.
// RULE_17: Window mode resets on restart before minimum or after maximum.
// RULE_18: Watchdog settings change only through the timed protected write.
// RULE_19: Always-on fuse keeps watchdog enabled despite software.
// RULE_20: Watchdog lock blocks setting changes until next reset.
// RULE_21: Status flags survive resets until software writes one to clear.
// RULE_22: Key write opens a short window; late protected writes dropped.
`include "rwc_defines.vh"

module rwc_top (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        por_below_i,
  input  wire        ext_reset_n_i,
  input  wire        bod_below_i,
  input  wire        bod_fuse_en_i,
  input  wire        scan_reset_bit_i,
  input  wire        program_debug_port_reset_i,
  input  wire        low_power_oscillator_i,
  input  wire        wdog_always_on_fuse_i,
  input  wire        watchdog_restart_instruction_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output wire [7:0]  reg_rdata_o,
  output wire        dev_reset_o,
  output wire        io_hiz_o,
  output wire [15:0] reset_vector_o,
  output wire [2:0]  bod_level_o,
  output wire        wdog_running_o
);

  // Three-stage samplers for every pin and the oscillator
  wire [5:0]  pin_raw;
  wire [5:0]  pin_s;
  wire [5:0]  pin_rise;

  // Every raw bit idles low, matching the sampler reset level
  assign pin_raw = {low_power_oscillator_i, program_debug_port_reset_i,
                    scan_reset_bit_i, bod_below_i & bod_fuse_en_i,
                    ~ext_reset_n_i, por_below_i};

  rwc_sync3 sync_por_u (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (pin_raw[0]),
    .lvl_o     (pin_s[0]),
    .rise_o    (pin_rise[0])
  );

  rwc_sync3 sync_ext_u (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (pin_raw[1]),
    .lvl_o     (pin_s[1]),
    .rise_o    (pin_rise[1])
  );

  rwc_sync3 sync_bod_u (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (pin_raw[2]),
    .lvl_o     (pin_s[2]),
    .rise_o    (pin_rise[2])
  );

  rwc_sync3 sync_scan_u (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (pin_raw[3]),
    .lvl_o     (pin_s[3]),
    .rise_o    (pin_rise[3])
  );

  rwc_sync3 sync_dbg_u (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (pin_raw[4]),
    .lvl_o     (pin_s[4]),
    .rise_o    (pin_rise[4])
  );

  rwc_sync3 sync_osc_u (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (pin_raw[5]),
    .lvl_o     (pin_s[5]),
    .rise_o    (pin_rise[5])
  );

  // Internal reset request stretcher for event sources
  reg  [4:0]  hold_cnt_q;
  reg  [4:0]  hold_cnt_d;
  wire        wdog_fire;
  wire        sw_fire;
  wire        hold_active;

  assign hold_active = (hold_cnt_q != 5'h00);

  always @* begin
    hold_cnt_d = hold_cnt_q;
    if (wdog_fire || sw_fire) begin
      hold_cnt_d = `RWC_RST_HOLD;
    end else if (hold_active) begin
      hold_cnt_d = hold_cnt_q - 5'h01;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hold_cnt_q <= 5'h00;
    end else begin
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // Reset merge: raw pins feed the output directly, no clock in the path
  wire pin_reset_raw;
  assign pin_reset_raw = por_below_i                         // RULE_06
                       | ~ext_reset_n_i                      // RULE_07
                       | (bod_below_i & bod_fuse_en_i)       // RULE_09
                       | scan_reset_bit_i                    // RULE_10
                       | program_debug_port_reset_i;         // RULE_11
  assign dev_reset_o = pin_reset_raw | hold_active;          // RULE_01
  assign io_hiz_o    = dev_reset_o;                          // RULE_04

  // Control registers fall back to reset values during any device reset
  wire cfg_rst;
  assign cfg_rst = !rst_n_i | (|pin_s[4:0]) | hold_active;   // RULE_02

  // Timed-write guard
  reg  [2:0]  prot_cnt_q;
  wire        wr_key;
  wire        prot_open;
  wire        prot_wr;

  assign wr_key    = reg_wr_i && (reg_addr_i == `RWC_ADDR_PROT_KEY);
  assign prot_open = (prot_cnt_q != 3'h0);
  assign prot_wr   = reg_wr_i && prot_open
                   && (reg_addr_i != `RWC_ADDR_PROT_KEY);

  always @(posedge clk_sys_i) begin
    if (cfg_rst) begin
      prot_cnt_q <= 3'h0;
    end else if (wr_key && reg_wdata_i == `RWC_PROT_KEY) begin
      prot_cnt_q <= `RWC_PROT_CYCLES;                        // RULE_22
    end else if (prot_wr) begin
      prot_cnt_q <= 3'h0;
    end else if (prot_open) begin
      prot_cnt_q <= prot_cnt_q - 3'h1;                       // RULE_22
    end
  end

  // Software reset only through the guard
  assign sw_fire = prot_wr && (reg_addr_i == `RWC_ADDR_SW_RESET)
                 && reg_wdata_i[0];                          // RULE_12

  // Watchdog settings
  reg  [7:0]  wdog_ctrl_q;
  reg  [7:0]  win_ctrl_q;
  reg         wdog_lock_q;
  reg  [2:0]  bod_lvl_q;
  reg         boot_vec_q;
  wire        cfg_wr_ok;

  assign cfg_wr_ok = prot_wr && !wdog_lock_q;                // RULE_18

  always @(posedge clk_sys_i) begin
    if (cfg_rst) begin
      wdog_ctrl_q <= `RWC_WDOG_CTRL_RST;
      win_ctrl_q  <= `RWC_WIN_CTRL_RST;
      wdog_lock_q <= 1'b0;
    end else begin
      if (cfg_wr_ok && reg_addr_i == `RWC_ADDR_WDOG_CTRL) begin
        wdog_ctrl_q <= {3'h0, reg_wdata_i[4:0]};             // RULE_20
      end
      if (cfg_wr_ok && reg_addr_i == `RWC_ADDR_WDOG_WINCTRL) begin
        win_ctrl_q <= {3'h0, reg_wdata_i[4:0]};              // RULE_20
      end
      // Lock is sticky; only a reset releases it
      if (prot_wr && reg_addr_i == `RWC_ADDR_WDOG_LOCK
          && reg_wdata_i[0]) begin
        wdog_lock_q <= 1'b1;                                 // RULE_20
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (cfg_rst) begin
      bod_lvl_q  <= `RWC_BOD_CTRL_RST;
      boot_vec_q <= `RWC_BOOT_CTRL_RST;
    end else begin
      if (reg_wr_i && reg_addr_i == `RWC_ADDR_BOD_CTRL) begin
        bod_lvl_q <= reg_wdata_i[`RWC_BOD_LVL_MSB:0];
      end
      if (prot_wr && reg_addr_i == `RWC_ADDR_BOOT_CTRL) begin
        boot_vec_q <= reg_wdata_i[0];
      end
    end
  end

  reg  [15:0] reset_vec_q;
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reset_vec_q <= 16'h0000;
    end else begin
      reset_vec_q <= boot_vec_q ? `RWC_BOOT_VECTOR : 16'h0000; // RULE_03
    end
  end
  assign reset_vector_o = reset_vec_q;
  assign bod_level_o    = bod_lvl_q;

  // Watchdog clocking: 1 kHz tick from the oscillator edges
  reg  [4:0]  lpo_div_q;
  reg         tick_q;
  wire        lpo_edge;

  assign lpo_edge = pin_rise[5];

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lpo_div_q <= 5'h00;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= lpo_edge && (lpo_div_q == `RWC_LPO_DIV);     // RULE_14
      if (lpo_edge) begin
        lpo_div_q <= lpo_div_q + 5'h01;
      end
    end
  end

  // Period limit: 8 ms doubled per step, codes above ten clamp
  wire [3:0]  per_code;
  wire [3:0]  win_code;
  wire [13:0] per_lim;
  wire [13:0] win_lim;
  wire        wdog_en;
  wire        win_en;

  assign per_code = (wdog_ctrl_q[4:1] > `RWC_WDOG_PER_MAX) ?
                    `RWC_WDOG_PER_MAX : wdog_ctrl_q[4:1];
  assign win_code = (win_ctrl_q[4:1] > `RWC_WDOG_PER_MAX) ?
                    `RWC_WDOG_PER_MAX : win_ctrl_q[4:1];
  assign per_lim  = `RWC_WDOG_BASE_MS << per_code;           // RULE_13
  assign win_lim  = `RWC_WDOG_BASE_MS << win_code;           // RULE_13
  assign wdog_en  = wdog_ctrl_q[0] | wdog_always_on_fuse_i;  // RULE_19
  assign win_en   = win_ctrl_q[0] & wdog_en;
  assign wdog_running_o = wdog_en;

  reg  [13:0] wdog_cnt_q;
  reg  [13:0] wdog_cnt_d;
  reg         wdog_fire_d;
  reg         wdog_fire_q;

  always @* begin
    wdog_cnt_d  = wdog_cnt_q;
    wdog_fire_d = 1'b0;
    if (!wdog_en) begin
      wdog_cnt_d = 14'h0000;
    end else if (watchdog_restart_instruction_i) begin
      wdog_cnt_d = 14'h0000;                                 // RULE_16
      if (win_en && wdog_cnt_q < win_lim) begin
        wdog_fire_d = 1'b1;                                  // RULE_17
      end
    end else if (tick_q) begin
      if (wdog_cnt_q >= per_lim - 14'h0001) begin
        wdog_fire_d = 1'b1;                                  // RULE_15
        wdog_cnt_d  = 14'h0000;
      end else begin
        wdog_cnt_d = wdog_cnt_q + 14'h0001;                  // RULE_15
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (cfg_rst) begin
      wdog_cnt_q  <= 14'h0000;
      wdog_fire_q <= 1'b0;
    end else begin
      wdog_cnt_q  <= wdog_cnt_d;
      wdog_fire_q <= wdog_fire_d;
    end
  end
  assign wdog_fire = wdog_fire_q & wdog_en;                  // RULE_08

  // Reset cause flags: cleared only by rst_n_i or write-one
  reg  [6:0]  rst_flags_q;
  wire [6:0]  flag_set;
  wire [6:0]  flag_clr;

  assign flag_set = {sw_fire, pin_rise[4], pin_rise[3], pin_rise[2],
                     wdog_fire, pin_rise[1], pin_rise[0]};
  assign flag_clr = (reg_wr_i && reg_addr_i == `RWC_ADDR_RST_STATUS) ?
                    reg_wdata_i[6:0] : 7'h00;

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rst_flags_q <= 7'h00;
    end else begin
      // Set wins over a simultaneous clear
      rst_flags_q <= (rst_flags_q & ~flag_clr) | flag_set;   // RULE_05 RULE_21
    end
  end

  // Read port: data one cycle after the read strobe
  reg  [7:0]  rdata_q;
  reg  [7:0]  rdata_d;

  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `RWC_ADDR_RST_STATUS:   rdata_d = {1'b0, rst_flags_q};  // RULE_05
      `RWC_ADDR_WDOG_CTRL:    rdata_d = {wdog_ctrl_q[7:1], wdog_en};
      `RWC_ADDR_WDOG_WINCTRL: rdata_d = win_ctrl_q;
      `RWC_ADDR_WDOG_LOCK:    rdata_d = {6'h00, prot_open, wdog_lock_q};
      `RWC_ADDR_BOD_CTRL:     rdata_d = {5'h00, bod_lvl_q};
      `RWC_ADDR_BOOT_CTRL:    rdata_d = {7'h00, boot_vec_q};
      `RWC_ADDR_WDOG_COUNT_LO: rdata_d = wdog_cnt_q[7:0];
      `RWC_ADDR_WDOG_COUNT_HI: rdata_d = {2'h0, wdog_cnt_q[13:8]};
      default:                rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_i ? rdata_d : 8'h00;
    end
  end
  assign reg_rdata_o = rdata_q;

endmodule

// One pin sampler: three sampling flops and a level flop, a change counts once two and three agree
module rwc_sync3 #(
  parameter [0:0] IDLE_LVL = 1'b0
) (
  input  wire clk_sys_i,
  input  wire rst_n_i,
  input  wire pin_i,
  output wire lvl_o,
  output wire rise_o
);

  reg  s1_q;
  reg  s2_q;
  reg  s3_q;
  reg  lvl_q;
  wire lvl_d;

  // Hysteresis: a single odd sample never flips the level
  assign lvl_d  = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  assign lvl_o  = lvl_d;
  assign rise_o = lvl_d & ~lvl_q;

  // Reset to the idle level so no false edge follows reset
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s1_q  <= IDLE_LVL;
      s2_q  <= IDLE_LVL;
      s3_q  <= IDLE_LVL;
      lvl_q <= IDLE_LVL;
    end else begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

endmodule

/* verification/rwc_chk.sv */
// Port assertions for the reset and watchdog controller
`timescale 1ns/1ps
module rwc_chk (
  input wire       clk_sys_i,
  input wire       rst_n_i,
  input wire       por_below_i,
  input wire       ext_reset_n_i,
  input wire       bod_below_i,
  input wire       bod_fuse_en_i,
  input wire       scan_reset_bit_i,
  input wire       program_debug_port_reset_i,
  input wire       wdog_always_on_fuse_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       dev_reset_o,
  input wire       io_hiz_o,
  input wire       wdog_running_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_POR: assert property (por_below_i |-> dev_reset_o)
    else $error("supply low without reset");
  AST_EXT: assert property (!ext_reset_n_i |-> dev_reset_o)
    else $error("pin low without reset");
  AST_BOD: assert property (
    bod_below_i && bod_fuse_en_i |-> dev_reset_o)
    else $error("brown-out without reset");
  AST_SCAN: assert property (scan_reset_bit_i |-> dev_reset_o)
    else $error("scan bit without reset");
  AST_DBG: assert property (
    program_debug_port_reset_i |-> dev_reset_o)
    else $error("debug request without reset");
  AST_HIZ: assert property (io_hiz_o == dev_reset_o)
    else $error("pins not tri-stated with reset");
  AST_FUSE: assert property (
    wdog_always_on_fuse_i |-> wdog_running_o)
    else $error("fuse set but watchdog off");
  AST_SW: assert property (
    reg_wr_i && reg_addr_i == 4'h1 && reg_wdata_i[0] &&
    $past(reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i == 8'hD8, 2)
    |=> dev_reset_o [*8])
    else $error("software reset not held");
endmodule

bind rwc_top rwc_chk chk_u (.clk_sys_i, .rst_n_i, .por_below_i,
  .ext_reset_n_i, .bod_below_i, .bod_fuse_en_i, .scan_reset_bit_i,
  .program_debug_port_reset_i, .wdog_always_on_fuse_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .dev_reset_o, .io_hiz_o, .wdog_running_o);

/* verification/rwc_partner.sv */
// Model of reset pin, debug port, supply monitors and low-power clock
`timescale 1ns/1ps
module rwc_partner #(
  parameter OSC_HALF = 4
) (
  input  wire       clk_sys_i,
  input  wire [4:0] src_i,
  output wire       por_below_o,
  output wire       ext_reset_n_o,
  output wire       bod_below_o,
  output wire       scan_reset_bit_o,
  output wire       dbg_reset_o,
  output reg        osc_o
);
  integer cnt_q = 0;
  assign por_below_o      = src_i[0];
  assign ext_reset_n_o    = !src_i[1];
  assign bod_below_o      = src_i[2];
  assign scan_reset_bit_o = src_i[3];
  assign dbg_reset_o      = src_i[4];
  // Free running; a larger half period gives a slower tick
  initial osc_o = 1'b0;
  always @(posedge clk_sys_i) begin
    cnt_q <= (cnt_q == OSC_HALF - 1) ? 0 : cnt_q + 1;
    if (cnt_q == OSC_HALF - 1) osc_o <= !osc_o;
  end
endmodule

/* verification/rwc_top_bench.sv */
// Self-checking bench for the reset and watchdog controller
`timescale 1ns/1ps
module rwc_top_bench;
  reg         clk_sys_i, rst_n_i, bod_fuse_en_i, wdog_always_on_fuse_i;
  reg         watchdog_restart_instruction_i, reg_wr_i, reg_rd_i;
  reg  [3:0]  reg_addr_i;
  reg  [7:0]  reg_wdata_i;
  reg  [4:0]  src_q;
  wire        por_below_i, ext_reset_n_i, bod_below_i, scan_reset_bit_i;
  wire        program_debug_port_reset_i, low_power_oscillator_i;
  wire [7:0]  reg_rdata_o;
  wire        dev_reset_o, io_hiz_o, wdog_running_o;
  wire [15:0] reset_vector_o;
  wire [2:0]  bod_level_o;
  integer     fails = 0;
  integer     checks = 0;
  reg  [7:0]  flag_v [0:4];
  rwc_top dut_u (.clk_sys_i, .rst_n_i, .por_below_i, .ext_reset_n_i,
    .bod_below_i, .bod_fuse_en_i, .scan_reset_bit_i,
    .program_debug_port_reset_i, .low_power_oscillator_i,
    .wdog_always_on_fuse_i, .watchdog_restart_instruction_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .dev_reset_o,
    .io_hiz_o, .reset_vector_o, .bod_level_o, .wdog_running_o);
  rwc_partner part_u (.clk_sys_i, .src_i(src_q),
    .por_below_o(por_below_i), .ext_reset_n_o(ext_reset_n_i),
    .bod_below_o(bod_below_i), .scan_reset_bit_o(scan_reset_bit_i),
    .dbg_reset_o(program_debug_port_reset_i),
    .osc_o(low_power_oscillator_i));
  task chk(input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0t %h %h", $time, seen, exp);
    end
  endtask
  task results;
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task prot(input [3:0] a, input [7:0] d);
    wr(4'h5, 8'hD8);
    wr(a, d);
  endtask
  task kick;
    @(posedge clk_sys_i) watchdog_restart_instruction_i <= 1'b1;
    @(posedge clk_sys_i) watchdog_restart_instruction_i <= 1'b0;
  endtask
  // Bounded wait on the device reset level; running out ends the run
  task waitv(input v, input integer n);
    integer i;
    #1;
    for (i = 0; i < n && dev_reset_o !== v; i = i + 1) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (dev_reset_o !== v) begin
      fails = fails + 1;
      results;
    end
  endtask
  task t_regs;
    wr(4'h0, 8'h7F);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'hF, 8'h00);
    wr(4'h6, 8'h05);
    rd(4'h6, 8'h05);
    chk(bod_level_o, 16'h0005);
    chk(reset_vector_o, 16'h0000);
  endtask
  task t_src;
    integer k;
    reg [7:0] acc;
    acc = 8'h00;
    bod_fuse_en_i <= 1'b0;
    src_q <= 5'h04;
    idle(3);
    chk(dev_reset_o, 1'b0);
    src_q <= 5'h00;
    bod_fuse_en_i <= 1'b1;
    for (k = 0; k < 5; k = k + 1) begin
      @(posedge clk_sys_i) src_q <= 5'h01 << k;
      #1 chk(dev_reset_o & io_hiz_o, 1'b1);
      idle(5);
      src_q <= 5'h00;
      idle(6);
      waitv(0, 40);
      acc = acc | flag_v[k];
      rd(4'h0, acc);
    end
    wr(4'h0, 8'h7F);
    rd(4'h0, 8'h00);
  endtask
  task t_boot;
    prot(4'h7, 8'h01);
    idle(2);
    chk(reset_vector_o, 16'h8000);
  endtask
  task t_sw;
    wr(4'h1, 8'h01);
    idle(2);
    chk(dev_reset_o, 1'b0);
    wr(4'h5, 8'hD8);
    idle(5);
    wr(4'h1, 8'h01);
    idle(2);
    chk(dev_reset_o, 1'b0);
    prot(4'h1, 8'h01);
    idle(15);
    #1 chk(dev_reset_o, 1'b1);
    waitv(0, 8);
    chk(reset_vector_o, 16'h0000);
    rd(4'h0, 8'h40);
    wr(4'h0, 8'h40);
  endtask
  task t_wdog;
    wr(4'h2, 8'h01);
    idle(1);
    chk(wdog_running_o, 1'b0);
    prot(4'h2, 8'h01);
    prot(4'h4, 8'h01);
    prot(4'h2, 8'h00);
    idle(1);
    chk(wdog_running_o, 1'b1);
    repeat (3) begin
      idle(1500);
      kick;
      chk(dev_reset_o, 1'b0);
    end
    idle(1700);
    chk(dev_reset_o, 1'b0);
    waitv(1, 700);
    waitv(0, 40);
    rd(4'h0, 8'h04);
    chk(wdog_running_o, 1'b0);
    prot(4'h3, 8'h01);
    prot(4'h2, 8'h03);
    kick;
    waitv(1, 20);
    waitv(0, 40);
    wdog_always_on_fuse_i <= 1'b1;
    idle(2);
    chk(wdog_running_o, 1'b1);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    rst_n_i = 1'b0;
    bod_fuse_en_i = 1'b1;
    wdog_always_on_fuse_i = 1'b0;
    watchdog_restart_instruction_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    src_q = 5'h00;
    flag_v[0] = 8'h01;
    flag_v[1] = 8'h02;
    flag_v[2] = 8'h08;
    flag_v[3] = 8'h10;
    flag_v[4] = 8'h20;
    idle(20);
    rst_n_i <= 1'b1;
    t_regs;
    t_src;
    t_boot;
    t_sw;
    t_wdog;
    results;
  end
endmodule
